// ===== src/pmec_pkg.sv
// Package: bit layout and constants of the monitor control register
package pmec_pkg;
   // Big-endian bit numbering: bit 0 is the MSB of a 32-bit word
   localparam int PMEC_W = 32;
   // Field positions are given in little-endian index (31 - printed bit)
   localparam int POS_GLOBAL_IRQ = 26;     // printed bit 5
   localparam int POS_FREEZE_IRQ = 25;     // printed bit 6
   localparam int POS_TAP_HI = 24;         // printed bits 7..8
   localparam int POS_TAP_LO = 23;
   localparam int POS_TAP_IRQ = 22;        // printed bit 9
   localparam int POS_THR_HI = 21;         // printed bits 10..15
   localparam int POS_THR_LO = 16;
   localparam int POS_C1_IRQ = 15;         // printed bit 16
   localparam int POS_C2_IRQ = 14;         // printed bit 17
   localparam int POS_C2_HOLD = 13;        // printed bit 18
   localparam int POS_C1_SEL_HI = 12;      // printed bits 19..25
   localparam int POS_C1_SEL_LO = 6;
   localparam int POS_C2_SEL_HI = 5;       // printed bits 26..31
   localparam int POS_C2_SEL_LO = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Time-base taps, as printed bit numbers (bit 0 = MSB of 64-bit base)
   localparam int TAP_BIT_00 = 63;
   localparam int TAP_BIT_01 = 55;
   localparam int TAP_BIT_10 = 51;
   localparam int TAP_BIT_11 = 47;
   localparam int TB_W = 64;
   localparam int C1_EVENTS = 128;
   localparam int C2_EVENTS = 64;
   localparam int CNT_W = 32;
   typedef enum logic [1:0] {
      PMEC_TAP_00 = 2'h0,
      PMEC_TAP_01 = 2'h1,
      PMEC_TAP_10 = 2'h2,
      PMEC_TAP_11 = 2'h3
   } pmec_tap_t;
endpackage : pmec_pkg

// ===== src/pmec_counter.sv
// Event counter with selectable event source and negative flag
`timescale 1ns/10ps
`default_nettype none
module pmec_counter #(
   parameter int SEL_W = 7,
   parameter int CNT_W = 32
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [(1<<SEL_W)-1:0] i_events,
   input wire logic [SEL_W-1:0] i_select,
   input wire logic i_run,
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_load_value,
   output logic [CNT_W-1:0] o_count,
   output logic o_negative
);
   wire logic hit;
   wire logic [CNT_W-1:0] next_count;

   // Chosen event; every select code indexes one of the 1<<SEL_W event inputs
   assign hit = i_events[i_select];
   assign next_count = i_load ? i_load_value :
                       ((i_run && hit) ? o_count + {{(CNT_W-1){1'b0}}, 1'b1} : o_count);

   // Count register; software load wins over an event
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_count <= '0;
      end else begin
         o_count <= next_count;
      end
   end

   assign o_negative = o_count[CNT_W-1];
endmodule : pmec_counter
`default_nettype wire

// ===== src/pmec_top.sv
// Performance monitor control register with two event counters
`timescale 1ns/10ps
`default_nettype none
module pmec_top (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_supervisor,
   input wire logic i_ctrl_write,
   input wire logic [31:0] i_ctrl_wdata,
   input wire logic i_ctrl_read,
   input wire logic i_cnt1_write,
   input wire logic i_cnt2_write,
   input wire logic [pmec_pkg::CNT_W-1:0] i_cnt_wdata,
   input wire logic [pmec_pkg::TB_W-1:0] i_time_base,
   input wire logic [pmec_pkg::C1_EVENTS-1:0] i_events_one,
   input wire logic [pmec_pkg::C2_EVENTS-1:0] i_events_two,
   output logic [31:0] o_ctrl_rdata,
   output logic [pmec_pkg::CNT_W-1:0] o_counter_one,
   output logic [pmec_pkg::CNT_W-1:0] o_counter_two,
   output logic [5:0] o_threshold,
   output logic o_monitor_irq
);
   import pmec_pkg::*;

   logic [31:0] monitor_mode_control_zero;
   logic tap_prev;
   logic frozen;
   logic c2_released;
   logic [CNT_W-1:0] cnt1_q;
   logic [CNT_W-1:0] cnt2_q;
   wire logic neg1;
   wire logic neg2;

   ////////////////////////////////////////////////////////////////////////
   // Field decode
   wire logic global_monitor_irq_enable = monitor_mode_control_zero[POS_GLOBAL_IRQ];
   wire logic freeze_on_irq = monitor_mode_control_zero[POS_FREEZE_IRQ];
   wire logic [1:0] time_base_tap_select = monitor_mode_control_zero[POS_TAP_HI:POS_TAP_LO];
   wire logic tap_transition_irq_enable = monitor_mode_control_zero[POS_TAP_IRQ];
   wire logic counter_one_negative_irq_enable = monitor_mode_control_zero[POS_C1_IRQ];
   wire logic counter_two_negative_irq_enable = monitor_mode_control_zero[POS_C2_IRQ];
   wire logic counter_two_trigger_hold = monitor_mode_control_zero[POS_C2_HOLD];
   wire logic [6:0] counter_one_event_select =
      monitor_mode_control_zero[POS_C1_SEL_HI:POS_C1_SEL_LO];
   wire logic [5:0] counter_two_event_select =
      monitor_mode_control_zero[POS_C2_SEL_HI:POS_C2_SEL_LO];

   // Printed bit n of the time base is index TB_W-1-n
   function automatic logic tb_bit(input logic [TB_W-1:0] tb, input int n);
      tb_bit = tb[TB_W-1-n];
   endfunction : tb_bit

   ////////////////////////////////////////////////////////////////////////
   // Time-base tap selection
   logic tap_now;
   always_comb begin
      unique case (pmec_tap_t'(time_base_tap_select))
         PMEC_TAP_00: tap_now = tb_bit(i_time_base, TAP_BIT_00);
         PMEC_TAP_01: tap_now = tb_bit(i_time_base, TAP_BIT_01);
         PMEC_TAP_10: tap_now = tb_bit(i_time_base, TAP_BIT_10);
         PMEC_TAP_11: tap_now = tb_bit(i_time_base, TAP_BIT_11);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt causes; time base is core-clock logic, so no synchroniser
   wire logic tap_rise = tap_now && !tap_prev;
   wire logic tap_cause = tap_transition_irq_enable && tap_rise;
   wire logic c1_cause = counter_one_negative_irq_enable && neg1;
   wire logic c2_cause = counter_two_negative_irq_enable && neg2;
   wire logic signal_irq = global_monitor_irq_enable &&
                           (tap_cause || c1_cause || c2_cause);

   // Supervisor gating; user-mode accesses are dropped silently
   wire logic ctrl_wr_ok = i_ctrl_write && i_supervisor;
   wire logic ctrl_rd_ok = i_ctrl_read && i_supervisor;

   ////////////////////////////////////////////////////////////////////////
   // Counter run enables
   // Counter two negative interrupt enable or trigger hold bypasses freeze for counter two
   wire logic freeze_now = frozen || (freeze_on_irq && signal_irq);
   // Release takes effect in the same cycle the trigger appears, not one later
   wire logic c2_hold_active = counter_two_trigger_hold && !c2_released
                               && !neg1 && !signal_irq;
   wire logic run1 = !freeze_now;
   wire logic run2 = !c2_hold_active &&
                     !(freeze_now && !counter_two_trigger_hold
                       && !counter_two_negative_irq_enable);

   pmec_counter #(.SEL_W(7), .CNT_W(CNT_W)) u_cnt1 (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_events(i_events_one),
      .i_select(counter_one_event_select),
      .i_run(run1),
      .i_load(i_cnt1_write && i_supervisor),
      .i_load_value(i_cnt_wdata),
      .o_count(cnt1_q),
      .o_negative(neg1)
   );

   pmec_counter #(.SEL_W(6), .CNT_W(CNT_W)) u_cnt2 (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_events(i_events_two),
      .i_select(counter_two_event_select),
      .i_run(run2),
      .i_load(i_cnt2_write && i_supervisor),
      .i_load_value(i_cnt_wdata),
      .o_count(cnt2_q),
      .o_negative(neg2)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control register; hardware clear of global enable beats a write
   logic [31:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl_wr_ok ? i_ctrl_wdata : monitor_mode_control_zero;
      if (signal_irq) begin
         next_ctrl[POS_GLOBAL_IRQ] = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         monitor_mode_control_zero <= CTRL_RESET;
      end else begin
         monitor_mode_control_zero <= next_ctrl;
      end
   end

   // Freeze latch and trigger release; cleared by a supervisor control write, but a set in the same cycle wins
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         frozen <= 1'b0;
         c2_released <= 1'b0;
         tap_prev <= 1'b0;
      end else begin
         tap_prev <= tap_now;
         frozen <= (freeze_on_irq && signal_irq) || (frozen && !ctrl_wr_ok);
         c2_released <= neg1 || signal_irq || (c2_released && !ctrl_wr_ok);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_ctrl_rdata <= 32'h0000_0000;
         o_counter_one <= '0;
         o_counter_two <= '0;
         o_threshold <= 6'h00;
         o_monitor_irq <= 1'b0;
      end else begin
         o_ctrl_rdata <= ctrl_rd_ok ? monitor_mode_control_zero : o_ctrl_rdata;
         o_counter_one <= cnt1_q;
         o_counter_two <= cnt2_q;
         o_threshold <= monitor_mode_control_zero[POS_THR_HI:POS_THR_LO];
         o_monitor_irq <= signal_irq;
      end
   end
endmodule : pmec_top
`default_nettype wire

// ===== sim/pmec_chk.sv
// Port checker for the monitor control block
`timescale 1ns/10ps
`default_nettype none
module pmec_chk (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_supervisor,
   input wire logic i_ctrl_write,
   input wire logic [31:0] i_ctrl_wdata,
   input wire logic i_ctrl_read,
   input wire logic i_cnt1_write,
   input wire logic [31:0] i_cnt_wdata,
   input wire logic [31:0] o_ctrl_rdata,
   input wire logic [31:0] o_counter_one,
   input wire logic [5:0] o_threshold,
   input wire logic o_monitor_irq
);
   logic wr, rd, ld, seen;
   assign wr = i_ctrl_write & i_supervisor;
   assign rd = i_ctrl_read & i_supervisor;
   assign ld = i_cnt1_write & i_supervisor;
   default clocking dc @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Pulse seen, no write since: enable must read back clear
   always_ff @(posedge i_clk) begin
      if (!i_rstn || wr) seen <= 1'h0;
      else if (o_monitor_irq) seen <= 1'h1;
   end
   a_irq_one_pulse: assert property (o_monitor_irq |=> !o_monitor_irq)
      else $error("irq pulse too long");
   a_enable_cleared: assert property (seen && rd |=> !o_ctrl_rdata[26])
      else $error("enable kept after irq");
   a_irq_gated: assert property (wr && !i_ctrl_wdata[26] ##1 !wr |=> !o_monitor_irq)
      else $error("irq while disabled");
   a_rdata_hold: assert property (!rd |=> $stable(o_ctrl_rdata))
      else $error("read data moved");
   a_rdata_echo: assert property (wr ##1 rd |=>
      (o_ctrl_rdata & 32'hfbff_ffff) == ($past(i_ctrl_wdata, 2) & 32'hfbff_ffff))
      else $error("read back differs");
   a_thr_field: assert property (wr ##1 !wr |=>
      o_threshold == $past(i_ctrl_wdata[21:16], 2)) else $error("bad threshold");
   a_cnt_load: assert property (ld |-> ##2 o_counter_one == $past(i_cnt_wdata, 2))
      else $error("load lost");
   a_cnt_step: assert property ($changed(o_counter_one) && !$past(ld) &&
      !$past(ld, 2) |-> o_counter_one == $past(o_counter_one) + 32'h1)
      else $error("count step not one");
endmodule : pmec_chk
`default_nettype wire
bind pmec_top pmec_chk i_chk (.i_clk, .i_rstn, .i_supervisor, .i_ctrl_write,
   .i_ctrl_wdata, .i_ctrl_read, .i_cnt1_write, .i_cnt_wdata, .o_ctrl_rdata,
   .o_counter_one, .o_threshold, .o_monitor_irq);

// ===== sim/testbench.sv
// Directed bench for the monitor control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pmec_pkg::*;
   logic i_clk = 0, i_rstn = 0, i_supervisor = 1, i_ctrl_write = 0, i_ctrl_read = 0;
   logic i_cnt1_write = 0, i_cnt2_write = 0, o_monitor_irq;
   logic [31:0] i_ctrl_wdata = 0, i_cnt_wdata = 0, o_ctrl_rdata, o_counter_one, v;
   logic [31:0] o_counter_two;
   logic [63:0] i_time_base = 0, i_events_two = 0;
   logic [127:0] i_events_one = 0;
   logic [5:0] o_threshold;
   int n_errors = 0, checks_done = 0, n_irq = 0, taps[4];
   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_monitor_irq === 1'h1) n_irq++;
   pmec_top i_dut (.i_clk, .i_rstn, .i_supervisor, .i_ctrl_write, .i_ctrl_wdata,
      .i_ctrl_read, .i_cnt1_write, .i_cnt2_write, .i_cnt_wdata, .i_time_base,
      .i_events_one, .i_events_two, .o_ctrl_rdata, .o_counter_one, .o_counter_two,
      .o_threshold, .o_monitor_irq);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   task automatic wr(input logic [31:0] d);
      i_ctrl_write <= 1'h1;
      i_ctrl_wdata <= d;
      cyc(1);
      i_ctrl_write <= 1'h0;
   endtask : wr
   // Data stands until the next read, so sampling late is safe
   task automatic rd(output logic [31:0] d);
      i_ctrl_read <= 1'h1;
      cyc(1);
      i_ctrl_read <= 1'h0;
      cyc(2);
      d = o_ctrl_rdata;
   endtask : rd
   task automatic ld(input logic two, input logic [31:0] d);
      {i_cnt2_write, i_cnt1_write} <= two ? 2'h2 : 2'h1;
      i_cnt_wdata <= d;
      cyc(1);
      {i_cnt2_write, i_cnt1_write} <= 2'h0;
   endtask : ld
   task automatic ev(input logic two, input int k, n);
      i_events_two[k] <= two;
      i_events_one[k] <= !two;
      cyc(n);
      i_events_one <= '0;
      i_events_two <= '0;
      cyc(3);
   endtask : ev
   task automatic end_of_test;
      if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      n_errors++;
      end_of_test;
   end
   // Main sequence
   initial begin
      taps = '{TAP_BIT_00, TAP_BIT_01, TAP_BIT_10, TAP_BIT_11};
      cyc(4);
      i_rstn <= 1'h1;
      rd(v);
      chk(v, 32'h0);
      wr(32'hfbff_ffff);
      rd(v);
      chk(v, 32'hfbff_ffff);
      chk(32'(o_threshold), 32'h3f);
      i_supervisor <= 1'h0;
      wr(32'h0);
      i_supervisor <= 1'h1;
      rd(v);
      chk(v, 32'hfbff_ffff);
      // Only the selected tap may raise the pulse
      foreach (taps[c]) begin
         wr(32'h0440_0000 | (32'(c) << 23));
         i_time_base <= ~(64'h1 << (63 - taps[c]));
         cyc(4);
         chk(n_irq, c);
         i_time_base <= '1;
         cyc(4);
         chk(n_irq, c + 1);
         i_time_base <= '0;
         cyc(1);
      end
      wr(32'h0400_0000);
      i_time_base <= '1;
      cyc(4);
      chk(n_irq, 4);
      ld(0, 32'h7fff_ffff);
      wr(32'h0600_8140);
      ev(0, 4, 2);
      chk(o_counter_one, 32'h7fff_ffff);
      ev(0, 5, 1);
      chk(n_irq, 5);
      ev(0, 5, 3);
      chk(o_counter_one, 32'h8000_0000);
      rd(v);
      chk(v, 32'h0200_8140);
      ld(0, 32'h0);
      cyc(1);
      ld(1, 32'h0);
      wr(32'h0000_2143);
      ev(1, 3, 3);
      chk(o_counter_two, 32'h0);
      ld(0, 32'h8000_0000);
      ev(1, 3, 3);
      ev(1, 2, 2);
      chk(o_counter_two, 32'h3);
      ld(1, 32'h7fff_ffff);
      wr(32'h0600_4003);
      ev(1, 3, 3);
      chk(n_irq, 6);
      chk(o_counter_two, 32'h8000_0002);
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
